// ==== motor_cfg_map.svh ====
// register indices, field positions, reset values and timing counts of the motor configuration bank
`ifndef MOTOR_CFG_MAP_SVH
`define MOTOR_CFG_MAP_SVH

// ****************************************************************
// register indices (five-bit word address)
// ****************************************************************
`define CFG_COUNT        22
`define REG_PERIOD_IDX   5'h00
`define REG_DEAD_IDX     5'h01
`define REG_SAVE_IDX     5'h1c
`define REG_MASK_IDX     5'h1d
`define REG_DIAG_IDX     5'h1e
`define REG_RUN_IDX      5'h1f

// ****************************************************************
// serial word layout
// ****************************************************************
`define WORD_ADDR_MSB    15
`define WORD_ADDR_LSB    11
`define WORD_PTR_ONLY    10
`define DATA_MSB         9
`define LINK_DEV_ADDR    7'h2a  // link address, value arbitrary

// ****************************************************************
// field positions
// ****************************************************************
`define SENSE_MSB        9
`define SENSE_LSB        8
`define PERIOD_MSB       7
`define PERIOD_LSB       0
`define DEAD_MSB         9
`define DEAD_LSB         4
`define HOLD_MSB         3
`define HOLD_LSB         0
`define SAVE_BIT         9
`define MASK_MSB         9
`define MASK_LSB         3

// ****************************************************************
// reset values
// ****************************************************************
`define CFG_RESET        10'h000
`define MASK_RESET       7'h00
`define RUN_RESET        10'h000
`define COUNT_MAX        10'h3ff

// ****************************************************************
// timing figures and derived counts (200 MHz logic clock)
// ****************************************************************
`define CLK_PERIOD_PS    5000
`define PWM_BASE_NS      30500
`define PWM_STEP_NS      400
`define DEAD_STEP_NS     50
`define DEAD_MIN_NS      100
`define DEAD_REC_NS      1500
`define HOLD_STEP_MS     100
`define PWM_BASE_CYC     ((`PWM_BASE_NS * 1000) / `CLK_PERIOD_PS)
`define PWM_STEP_CYC     ((`PWM_STEP_NS * 1000) / `CLK_PERIOD_PS)
`define DEAD_STEP_CYC    ((`DEAD_STEP_NS * 1000) / `CLK_PERIOD_PS)
`define DEAD_MIN_CYC     ((`DEAD_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DEAD_REC_CYC     ((`DEAD_REC_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== motor_cfg_pkg.sv ====
// types shared by the motor configuration bank
`default_nettype none
package motor_cfg_pkg;
	// serial link byte-level states
	typedef enum logic [2:0] {
		LK_IDLE,
		LK_DEV,
		LK_DEVACK,
		LK_WR,
		LK_WRACK,
		LK_RD,
		LK_RDACK
	} link_state_t;
endpackage : motor_cfg_pkg
`default_nettype wire

// ==== link_sampler.sv ====
// two-stage synchroniser and edge, start and stop detector for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module link_sampler (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic scl_pin,
	input  wire logic sda_pin,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      sda_lvl,
	output logic      start_det,
	output logic      stop_det
);
	logic scl_m_ff;
	logic scl_s_ff;
	logic scl_d_ff;
	logic sda_m_ff;
	logic sda_s_ff;
	logic sda_d_ff;

	// synchroniser chains, idle bus level is high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else if (ce) begin
			scl_m_ff <= scl_pin;
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= sda_pin;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end
	end

	// edges look only at the second and third stages
	assign scl_rise  = scl_s_ff & ~scl_d_ff;
	assign scl_fall  = ~scl_s_ff & scl_d_ff;
	assign sda_lvl   = sda_s_ff;
	assign start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
	assign stop_det  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
endmodule : link_sampler
`default_nettype wire

// ==== motor_cfg_regs.sv ====
// configuration, save-control and diagnostic register bank behind the serial link
//
// Operation
// - sense-range code selects full scale 500, 250, 125 or 62.5 mV.
// - PWM period equals 30.5 us plus code times 0.4 us.
// - dead time is code times 50 ns, never below 100 ns.
// - save-control write carries the save trigger in bit 9 only.
// - save-control read returns the ten-bit write-cycle count in bits 9..0.
// - fault mask holds seven mask bits in bits 9..3.
// - diagnostic read gives six critical flags on top, seven fault flags below.
// - words are sixteen bits, MSB first, top five bits the address.
// - trigger going one to zero starts one whole nonvolatile save.
// - overcurrent hold time equals (1 + code) times 100 ms.
`timescale 1ns/1ps
`default_nettype none
`include "motor_cfg_map.svh"
module motor_cfg_regs #(
	parameter logic [6:0] DEV_ADDR = `LINK_DEV_ADDR
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	output var  logic        SDA_OUT,
	output var  logic        SDA_OE_N,
	input  wire logic [6:0]  FAULT_IN,
	input  wire logic [2:0]  ERR_IN,
	input  wire logic        SAVE_DONE,
	input  wire logic        SAVE_FAIL,
	input  wire logic        NV_LOAD_VALID,
	input  wire logic [4:0]  NV_LOAD_ADDR,
	input  wire logic [9:0]  NV_LOAD_DATA,
	output var  logic        SAVE_START,
	output var  logic [10:0] SENSE_FS_HALF_MV,
	output var  logic [14:0] PWM_PERIOD_CYC,
	output var  logic [9:0]  DEAD_TIME_CYC,
	output var  logic        DEAD_TIME_LOW,
	output var  logic [10:0] OC_HOLD_MS,
	output var  logic [9:0]  RUN_CTRL,
	output var  logic        CRITICAL_FAULT
);
	// ****************************************************************
	// declarations
	// ****************************************************************
	motor_cfg_pkg::link_state_t st_ff;
	logic [3:0]  cnt_ff;
	logic [7:0]  sh_ff;
	logic [7:0]  hi_ff;
	logic [7:0]  rd_lo_ff;
	logic        wr_hi_ff;
	logic        rd_hi_ff;
	logic        ack_ff;
	logic        oe_n_ff;
	logic [4:0]  ptr_ff;
	logic [9:0]  cfg_ff [0:`CFG_COUNT-1];
	logic        trig_ff;
	logic        start_ff;
	logic [6:0]  mask_ff;
	logic [9:0]  run_ff;
	logic [9:0]  count_ff;
	logic [6:0]  flags_ff;
	logic [5:0]  crit_ff;
	logic [6:0]  nxt_flags;
	logic [15:0] rd_word;
	logic [15:0] wr_word;
	logic        wr_go;
	logic        wr_store;
	logic [4:0]  wr_addr;
	logic [9:0]  wr_data;
	logic        scl_rise;
	logic        scl_fall;
	logic        sda_lvl;
	logic        start_det;
	logic        stop_det;
	logic [1:0]  sense_sel;
	logic [7:0]  period_code;
	logic [5:0]  dead_code;
	logic [3:0]  hold_code;
	logic [9:0]  dead_raw;
	logic [9:0]  dead_cyc;

	// pin sampling
	link_sampler u_sampler (
		.clk       (CLK),
		.rst       (RST),
		.ce        (CE),
		.scl_pin   (SCL_IN),
		.sda_pin   (SDA_IN),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.sda_lvl   (sda_lvl),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// ****************************************************************
	// serial link byte engine
	// ****************************************************************
	// word framing
	assign wr_word  = {hi_ff, sh_ff};
	assign wr_go    = (st_ff == motor_cfg_pkg::LK_WR) && scl_fall && (cnt_ff == 4'h8) && !wr_hi_ff;
	assign wr_addr  = wr_word[`WORD_ADDR_MSB:`WORD_ADDR_LSB];
	assign wr_data  = wr_word[`DATA_MSB:0];
	assign wr_store = wr_go && !wr_word[`WORD_PTR_ONLY];

	// byte receive, acknowledge and transmit; open drain only ever pulls low
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_ff    <= motor_cfg_pkg::LK_IDLE;
			cnt_ff   <= 4'h0;
			sh_ff    <= 8'h00;
			hi_ff    <= 8'h00;
			rd_lo_ff <= 8'h00;
			wr_hi_ff <= 1'b1;
			rd_hi_ff <= 1'b1;
			ack_ff   <= 1'b0;
			oe_n_ff  <= 1'b1;
			ptr_ff   <= 5'h00;
		end else if (CE) begin
			if (start_det) begin
				st_ff   <= motor_cfg_pkg::LK_DEV;
				cnt_ff  <= 4'h0;
				oe_n_ff <= 1'b1;
			end else if (stop_det) begin
				st_ff   <= motor_cfg_pkg::LK_IDLE;
				oe_n_ff <= 1'b1;
			end else begin
				unique case (st_ff)
					motor_cfg_pkg::LK_IDLE: begin
					end
					motor_cfg_pkg::LK_DEV, motor_cfg_pkg::LK_WR: begin
						if (scl_rise && cnt_ff != 4'h8) begin
							sh_ff  <= {sh_ff[6:0], sda_lvl};
							cnt_ff <= cnt_ff + 4'h1;
						end else if (scl_fall && cnt_ff == 4'h8) begin
							cnt_ff <= 4'h0;
							if (st_ff == motor_cfg_pkg::LK_WR) begin
								oe_n_ff  <= 1'b0;
								st_ff    <= motor_cfg_pkg::LK_WRACK;
								wr_hi_ff <= !wr_hi_ff;
								if (wr_hi_ff) begin
									hi_ff <= sh_ff;
								end
								if (wr_go) begin
									ptr_ff <= wr_addr;
								end
							end else if (sh_ff[7:1] == DEV_ADDR) begin
								oe_n_ff <= 1'b0;
								ack_ff  <= sh_ff[0];
								st_ff   <= motor_cfg_pkg::LK_DEVACK;
							end else begin
								st_ff <= motor_cfg_pkg::LK_IDLE;
							end
						end
					end
					motor_cfg_pkg::LK_DEVACK: begin
						if (scl_fall) begin
							wr_hi_ff <= 1'b1;
							if (ack_ff) begin
								sh_ff    <= rd_word[15:8];
								rd_lo_ff <= rd_word[7:0];
								oe_n_ff  <= rd_word[15];
								rd_hi_ff <= 1'b0;
								st_ff    <= motor_cfg_pkg::LK_RD;
							end else begin
								oe_n_ff <= 1'b1;
								st_ff   <= motor_cfg_pkg::LK_WR;
							end
						end
					end
					motor_cfg_pkg::LK_WRACK: begin
						if (scl_fall) begin
							oe_n_ff <= 1'b1;
							st_ff   <= motor_cfg_pkg::LK_WR;
						end
					end
					motor_cfg_pkg::LK_RD: begin
						if (scl_fall) begin
							if (cnt_ff == 4'h7) begin
								cnt_ff  <= 4'h0;
								oe_n_ff <= 1'b1;
								st_ff   <= motor_cfg_pkg::LK_RDACK;
							end else begin
								sh_ff   <= {sh_ff[6:0], 1'b0};
								oe_n_ff <= sh_ff[6];
								cnt_ff  <= cnt_ff + 4'h1;
							end
						end
					end
					motor_cfg_pkg::LK_RDACK: begin
						if (scl_rise) begin
							ack_ff <= !sda_lvl;
						end else if (scl_fall) begin
							if (ack_ff && rd_hi_ff) begin
								sh_ff    <= rd_word[15:8];
								rd_lo_ff <= rd_word[7:0];
								oe_n_ff  <= rd_word[15];
								rd_hi_ff <= 1'b0;
								st_ff    <= motor_cfg_pkg::LK_RD;
							end else if (ack_ff) begin
								sh_ff    <= rd_lo_ff;
								oe_n_ff  <= rd_lo_ff[7];
								rd_hi_ff <= 1'b1;
								st_ff    <= motor_cfg_pkg::LK_RD;
							end else begin
								st_ff <= motor_cfg_pkg::LK_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	// configuration words, serial write beats a restore in the same cycle
	for (genvar gi = 0; gi < `CFG_COUNT; gi++) begin : g_cfg
		always_ff @(posedge CLK or posedge RST) begin
			if (RST) begin
				cfg_ff[gi] <= `CFG_RESET;
			end else if (CE) begin
				if (wr_store && wr_addr == 5'(gi)) begin
					cfg_ff[gi] <= wr_data;
				end else if (NV_LOAD_VALID && NV_LOAD_ADDR == 5'(gi)) begin
					cfg_ff[gi] <= NV_LOAD_DATA;
				end
			end
		end
	end

	// save trigger and one-cycle save start
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			trig_ff  <= 1'b0;
			start_ff <= 1'b0;
		end else if (CE) begin
			start_ff <= wr_store && wr_addr == `REG_SAVE_IDX && trig_ff && !wr_data[`SAVE_BIT];
			if (wr_store && wr_addr == `REG_SAVE_IDX) begin
				trig_ff <= wr_data[`SAVE_BIT];
			end
		end
	end

	// fault mask and run word
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mask_ff <= `MASK_RESET;
			run_ff  <= `RUN_RESET;
		end else if (CE) begin
			if (wr_store && wr_addr == `REG_MASK_IDX) begin
				mask_ff <= wr_data[`MASK_MSB:`MASK_LSB];
			end
			if (wr_store && wr_addr == `REG_RUN_IDX) begin
				run_ff <= wr_data;
			end
		end
	end

	// write-cycle count, wraps once and then sticks at its top
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			count_ff <= 10'h000;
		end else if (CE && SAVE_DONE) begin
			if (count_ff != `COUNT_MAX) begin
				count_ff <= count_ff + 10'h001;
			end else if (!crit_ff[0]) begin
				count_ff <= 10'h000;
			end
		end
	end

	// latched flags: new events win over the clear by a finished save
	assign nxt_flags = (flags_ff & ~{7{SAVE_DONE}}) | FAULT_IN;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flags_ff <= 7'h00;
			crit_ff  <= 6'h10;
		end else if (CE) begin
			flags_ff   <= nxt_flags;
			crit_ff[5] <= (crit_ff[5] & ~SAVE_DONE) | SAVE_FAIL | (|(nxt_flags & ~mask_ff)) | (|ERR_IN);
			crit_ff[4] <= crit_ff[4] & ~SAVE_DONE;
			crit_ff[3:1] <= (crit_ff[3:1] & ~{3{SAVE_DONE}}) | ERR_IN;
			crit_ff[0] <= crit_ff[0] | (SAVE_DONE && count_ff == `COUNT_MAX);
		end
	end

	// read data for the word pointer
	always_comb begin
		rd_word = 16'h0000;
		if (ptr_ff < 5'(`CFG_COUNT)) begin
			rd_word = {6'h00, cfg_ff[ptr_ff]};
		end else if (ptr_ff == `REG_SAVE_IDX) begin
			rd_word = {6'h00, count_ff};
		end else if (ptr_ff == `REG_MASK_IDX) begin
			rd_word = {6'h00, mask_ff, 3'h0};
		end else if (ptr_ff == `REG_DIAG_IDX) begin
			rd_word = {crit_ff, flags_ff, 3'h0};
		end else if (ptr_ff == `REG_RUN_IDX) begin
			rd_word = {6'h00, run_ff};
		end
	end

	// ****************************************************************
	// field decode
	// ****************************************************************
	assign sense_sel   = cfg_ff[`REG_PERIOD_IDX][`SENSE_MSB:`SENSE_LSB];
	assign period_code = cfg_ff[`REG_PERIOD_IDX][`PERIOD_MSB:`PERIOD_LSB];
	assign dead_code   = cfg_ff[`REG_DEAD_IDX][`DEAD_MSB:`DEAD_LSB];
	assign hold_code   = cfg_ff[`REG_DEAD_IDX][`HOLD_MSB:`HOLD_LSB];
	assign dead_raw    = 10'(dead_code) * 10'(`DEAD_STEP_CYC);
	assign dead_cyc    = (dead_raw < 10'(`DEAD_MIN_CYC)) ? 10'(`DEAD_MIN_CYC) : dead_raw;

	// decoded settings for the control loops, in clock cycles, half millivolts or milliseconds
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			SENSE_FS_HALF_MV <= 11'h3e8;
			PWM_PERIOD_CYC   <= 15'(`PWM_BASE_CYC);
			DEAD_TIME_CYC    <= 10'(`DEAD_MIN_CYC);
			DEAD_TIME_LOW    <= 1'b1;
			OC_HOLD_MS       <= 11'(`HOLD_STEP_MS);
		end else if (CE) begin
			unique case (sense_sel)
				2'h0: SENSE_FS_HALF_MV <= 11'h3e8;
				2'h1: SENSE_FS_HALF_MV <= 11'h1f4;
				2'h2: SENSE_FS_HALF_MV <= 11'h0fa;
				2'h3: SENSE_FS_HALF_MV <= 11'h07d;
			endcase
			PWM_PERIOD_CYC <= 15'(`PWM_BASE_CYC) + 15'(period_code) * 15'(`PWM_STEP_CYC);
			DEAD_TIME_CYC  <= dead_cyc;
			DEAD_TIME_LOW  <= dead_cyc < 10'(`DEAD_REC_CYC);
			OC_HOLD_MS     <= (11'(hold_code) + 11'h001) * 11'(`HOLD_STEP_MS);
		end
	end

	// registered outputs
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			SDA_OUT        <= 1'b0;
			SDA_OE_N       <= 1'b1;
			SAVE_START     <= 1'b0;
			RUN_CTRL       <= `RUN_RESET;
			CRITICAL_FAULT <= 1'b0;
		end else if (CE) begin
			SDA_OUT        <= 1'b0;
			SDA_OE_N       <= oe_n_ff;
			SAVE_START     <= start_ff;
			RUN_CTRL       <= run_ff;
			CRITICAL_FAULT <= crit_ff[5];
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sense_range_a: assert property (CE && sense_sel == 2'h3 |=> SENSE_FS_HALF_MV == 11'h07d)
		else $error("sense full scale wrong for smallest range");
	pwm_period_a: assert property (CE |=> PWM_PERIOD_CYC == 15'd6100 + 15'($past(period_code)) * 15'd80)
		else $error("pwm period count does not follow code");
	dead_floor_a: assert property (CE |=> DEAD_TIME_CYC >= 10'd20 && ($past(dead_code) < 6'd2 || DEAD_TIME_CYC == 10'($past(dead_code)) * 10'd10))
		else $error("dead time count wrong");
	save_start_a: assert property (CE && wr_store && wr_addr == `REG_SAVE_IDX && trig_ff && !wr_data[`SAVE_BIT] ##1 CE |=> SAVE_START)
		else $error("falling save trigger did not start a save");
	save_pulse_a: assert property (CE && SAVE_START |=> !SAVE_START)
		else $error("save start longer than one cycle");
	count_step_a: assert property (CE && SAVE_DONE && count_ff != `COUNT_MAX |=>
		count_ff == $past(count_ff) + 10'h001)
		else $error("write count did not step after a finished save");
	mask_store_a: assert property (CE && wr_store && wr_addr == `REG_MASK_IDX |=> mask_ff == $past(wr_data[`MASK_MSB:`MASK_LSB]))
		else $error("mask word not stored from bits 9 to 3");
	diag_read_a: assert property (ptr_ff == `REG_DIAG_IDX |-> rd_word[15:10] == crit_ff && rd_word[9:3] == flags_ff)
		else $error("diagnostic word layout wrong");
	word_addr_a: assert property (CE && wr_go |=> ptr_ff == $past(wr_word[15:11]))
		else $error("word address not taken from top five bits");
	hold_time_a: assert property (CE && hold_code == 4'hf |=> OC_HOLD_MS == 11'd1600)
		else $error("longest overcurrent hold wrong");
	upper_zero_a: assert property (ptr_ff != `REG_DIAG_IDX |-> rd_word[15:10] == 6'h00)
		else $error("unused upper bits not zero");
	flag_set_a: assert property (CE && SAVE_DONE && FAULT_IN[0] |=> flags_ff[0])
		else $error("fault lost against save clear");
endmodule : motor_cfg_regs
`default_nettype wire

// ==== host_link.sv ====
// host-side model of the serial link: open-drain data, clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module host_link (
	output logic      scl,
	output logic      sda_rel,
	input  wire logic sda
);
	// ****************************************************************
	// idle bus
	// ****************************************************************
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	// ****************************************************************
	// link conditions and bits, 48 ns per bit
	// ****************************************************************
	// data moves only while the clock is low
	task automatic bitx(input logic b, output logic s);
		#12 sda_rel = b;
		#12 scl = 1'b1;
		#12 s = sda;
		#12 scl = 1'b0;
	endtask : bitx

	// start or repeated start, with room for the device to let go of data
	task automatic start_cond;
		#24 sda_rel = 1'b1;
		#12 scl = 1'b1;
		#12 sda_rel = 1'b0;
		#12 scl = 1'b0;
	endtask : start_cond

	task automatic stop_cond;
		#12 sda_rel = 1'b0;
		#12 scl = 1'b1;
		#12 sda_rel = 1'b1;
		#12;
	endtask : stop_cond

	task automatic wbyte(input logic [7:0] b, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitx(b[i], s);
		bitx(1'b1, nak);
	endtask : wbyte

	task automatic rbyte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, s);
			b[i] = s;
		end
		bitx(last, s);
	endtask : rbyte
endmodule : host_link
`default_nettype wire

// ==== motor_cfg_regs_test.sv ====
// self-checking bench for the motor configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "motor_cfg_map.svh"
module motor_cfg_regs_test;
	logic        CLK, RST, CE, scl, sda_rel, SDA_OUT, SDA_OE_N, SAVE_DONE, SAVE_FAIL, NV_LOAD_VALID;
	logic        SAVE_START, DEAD_TIME_LOW, CRITICAL_FAULT, nak;
	logic [6:0]  FAULT_IN;
	logic [2:0]  ERR_IN;
	logic [4:0]  NV_LOAD_ADDR;
	logic [9:0]  NV_LOAD_DATA, RUN_CTRL, DEAD_TIME_CYC;
	logic [10:0] SENSE_FS_HALF_MV, OC_HOLD_MS;
	logic [14:0] PWM_PERIOD_CYC;
	wire         sda_w = sda_rel & (SDA_OE_N | SDA_OUT);
	int          fails = 0, n_compared = 0, seed = 43, n_start = 0, cnt = 0, diag = 'h4000;
	int          cfg[32];
	int          dt[8] = '{0, 1, 2, 3, 29, 30, 31, 63};

	// ****************************************************************
	// clock, instances, save pulse counter
	// ****************************************************************
	initial CLK = 1'b0;
	always #2.5 CLK = ~CLK;

	motor_cfg_regs motor_cfg_regs_inst (.CLK(CLK), .RST(RST), .CE(CE), .SCL_IN(scl), .SDA_IN(sda_w),
		.SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .FAULT_IN(FAULT_IN), .ERR_IN(ERR_IN),
		.SAVE_DONE(SAVE_DONE), .SAVE_FAIL(SAVE_FAIL), .NV_LOAD_VALID(NV_LOAD_VALID),
		.NV_LOAD_ADDR(NV_LOAD_ADDR), .NV_LOAD_DATA(NV_LOAD_DATA), .SAVE_START(SAVE_START),
		.SENSE_FS_HALF_MV(SENSE_FS_HALF_MV), .PWM_PERIOD_CYC(PWM_PERIOD_CYC), .DEAD_TIME_CYC(DEAD_TIME_CYC),
		.DEAD_TIME_LOW(DEAD_TIME_LOW), .OC_HOLD_MS(OC_HOLD_MS), .RUN_CTRL(RUN_CTRL),
		.CRITICAL_FAULT(CRITICAL_FAULT));
	host_link host_link_inst (.scl(scl), .sda_rel(sda_rel), .sda(sda_w));

	// counts cycles with the save request high
	always @(posedge CLK)
		if (SAVE_START === 1'b1)
			n_start <= n_start + 1;

	// ****************************************************************
	// compare, report and closing tasks
	// ****************************************************************
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		cmp(got, exp, "read");
	endtask : chk_reg

	task automatic chk_dec(input logic [15:0] got, input logic [15:0] exp);
		cmp(got, exp, "output");
	endtask : chk_dec

	task automatic tdone(input string name);
		$display("test %s done, mismatches so far %0d", name, fails);
	endtask : tdone

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// ****************************************************************
	// link transfers and reference model
	// ****************************************************************
	task automatic xfer(input logic [4:0] a, input logic p, input logic [9:0] d);
		logic [15:0] w;
		w = {a, p, d};
		// pins move between rising clock edges, never on one
		@(negedge CLK);
		host_link_inst.start_cond();
		host_link_inst.wbyte({`LINK_DEV_ADDR, 1'b0}, nak);
		chk_dec({15'h0000, nak}, 16'h0000);
		host_link_inst.wbyte(w[15:8], nak);
		host_link_inst.wbyte(w[7:0], nak);
		chk_dec({15'h0000, nak}, 16'h0000);
	endtask : xfer

	// model stores only what the map keeps
	task automatic wr(input int a, input logic [9:0] d);
		xfer(5'(a), 1'b0, d);
		host_link_inst.stop_cond();
		repeat (4) @(posedge CLK);
		if (a < 22 || a == 31)
			cfg[a] = int'(d);
		if (a == 29)
			cfg[a] = int'(d) & 'h3f8;
	endtask : wr

	function automatic logic [15:0] exp_rd(input int a);
		if (a < 22 || a == 29 || a == 31)
			return 16'(cfg[a]);
		if (a == 28)
			return 16'(cnt);
		if (a == 30)
			return 16'(diag);
		return 16'h0000;
	endfunction : exp_rd

	task automatic rd_word(input int a);
		logic [15:0] v;
		logic [15:0] u;
		xfer(5'(a), 1'b1, 10'h000);
		host_link_inst.start_cond();
		host_link_inst.wbyte({`LINK_DEV_ADDR, 1'b1}, nak);
		host_link_inst.rbyte(1'b0, v[15:8]);
		host_link_inst.rbyte(1'b0, v[7:0]);
		host_link_inst.rbyte(1'b0, u[15:8]);
		host_link_inst.rbyte(1'b1, u[7:0]);
		host_link_inst.stop_cond();
		chk_reg(v, exp_rd(a));
		chk_reg(u, exp_rd(a));
	endtask : rd_word

	task automatic dec_chk;
		int n;
		n = (cfg[1] >> 4) * 10;
		chk_dec(16'(SENSE_FS_HALF_MV), 16'(1000 >> (cfg[0] >> 8)));
		chk_dec(16'(PWM_PERIOD_CYC), 16'(6100 + 80 * (cfg[0] & 255)));
		chk_dec(16'(DEAD_TIME_CYC), 16'((n < 20) ? 20 : n));
		chk_dec(16'(DEAD_TIME_LOW), 16'(n < 300));
		chk_dec(16'(OC_HOLD_MS), 16'(100 * (1 + (cfg[1] & 15))));
		chk_dec(16'(RUN_CTRL), 16'(cfg[31]));
	endtask : dec_chk

	task automatic pulse_in(input logic [6:0] f, input logic [2:0] e, input logic [1:0] s);
		@(posedge CLK);
		FAULT_IN <= f;
		ERR_IN <= e;
		SAVE_DONE <= s[0];
		SAVE_FAIL <= s[1];
		@(posedge CLK);
		FAULT_IN <= 7'h00;
		ERR_IN <= 3'h0;
		SAVE_DONE <= 1'b0;
		SAVE_FAIL <= 1'b0;
		repeat (4) @(posedge CLK);
	endtask : pulse_in

	// ****************************************************************
	// main sequence and hang guard
	// ****************************************************************
	initial begin
		repeat (90000) @(posedge CLK);
		fails++;
		complete_run();
	end

	initial begin
		RST = 1'b1;
		CE = 1'b1;
		FAULT_IN = 7'h00;
		ERR_IN = 3'h0;
		SAVE_DONE = 1'b0;
		SAVE_FAIL = 1'b0;
		NV_LOAD_VALID = 1'b0;
		NV_LOAD_ADDR = 5'h00;
		NV_LOAD_DATA = 10'h000;
		foreach (cfg[i])
			cfg[i] = 0;
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		repeat (3) @(posedge CLK);
		dec_chk();
		for (int a = 28; a < 32; a++)
			rd_word(a);
		tdone("reset");
		// decode every range code and dead-time edges
		// codes from 30 up meet the recommended floor, lower ones raise the flag
		for (int i = 0; i < 8; i++) begin
			wr(0, {2'(i), (i == 7) ? 8'hff : 8'($random(seed))});
			wr(1, {6'(dt[i]), 4'(i * 2 + 1)});
			dec_chk();
		end
		tdone("decode");
		// store and read back, unmapped words stay zero
		for (int a = 2; a < 32; a++)
			if (a != 28)
				wr(a, 10'($random(seed)));
		for (int a = 0; a < 32; a++)
			rd_word(a);
		dec_chk();
		tdone("readback");
		// flags latch, mask gates the critical flag
		wr(29, 10'h3ff);
		pulse_in(7'h55, 3'h0, 2'b00);
		diag = diag | ('h55 << 3);
		rd_word(30);
		chk_dec(16'(CRITICAL_FAULT), 16'h0000);
		wr(29, 10'h3df);
		pulse_in(7'h04, 3'h0, 2'b00);
		pulse_in(7'h00, 3'h7, 2'b00);
		diag = diag | 'hb820;
		rd_word(30);
		chk_dec(16'(CRITICAL_FAULT), 16'h0001);
		tdone("faults");
		// only a one to zero trigger starts a save
		wr(28, 10'h000);
		wr(28, 10'h3ff);
		wr(28, 10'h1ff);
		chk_dec(16'(n_start), 16'h0001);
		pulse_in(7'h00, 3'h0, 2'b01);
		cnt = 1;
		diag = 0;
		rd_word(28);
		rd_word(30);
		chk_dec(16'(CRITICAL_FAULT), 16'h0000);
		// count wraps once, then sticks at its top
		repeat (1023) pulse_in(7'h00, 3'h0, 2'b01);
		cnt = 0;
		diag = 'h0400;
		rd_word(28);
		rd_word(30);
		repeat (1024) pulse_in(7'h00, 3'h0, 2'b01);
		cnt = 1023;
		rd_word(28);
		pulse_in(7'h00, 3'h0, 2'b10);
		diag = diag | 'h8000;
		rd_word(30);
		chk_dec(16'(CRITICAL_FAULT), 16'h0001);
		// a fault and an error in the cycle of a finished save win over its clear
		pulse_in(7'h01, 3'h1, 2'b01);
		diag = 'h8c08;
		rd_word(30);
		chk_dec(16'(CRITICAL_FAULT), 16'h0001);
		tdone("save");
		// restored word lands in the bank
		@(posedge CLK);
		NV_LOAD_VALID <= 1'b1;
		NV_LOAD_ADDR <= 5'd16;
		NV_LOAD_DATA <= 10'h2a5;
		@(posedge CLK);
		NV_LOAD_VALID <= 1'b0;
		cfg[16] = 'h2a5;
		rd_word(16);
		// a foreign link address gets no acknowledge
		host_link_inst.start_cond();
		host_link_inst.wbyte({7'h2b, 1'b0}, nak);
		host_link_inst.stop_cond();
		chk_dec({15'h0000, nak}, 16'h0001);
		tdone("restore and address");
		complete_run();
	end
endmodule : motor_cfg_regs_test
`default_nettype wire
